// ---- sbcic_ctrl_status.sv ----
// module: interrupt control low bits and interrupt status register of the basis chip
`timescale 1ns/1ns
module sbcic_ctrl_status
    import sbcic_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input sbcic_wr_t wrReq,
    input wire logic [2:0] rdAddr,
    output logic [15:0] rdData,
    input sbcic_evt_t evt,
    input wire logic [1:0] chipModeField,
    input wire logic leaveOff,
    input wire logic wdTimeoutMode,
    input wire logic wakeBiasOutput,
    input wire logic wakeInputA,
    input wire logic wakeInputB,
    output sbcic_xcvr_t canXcvrMode,
    output logic canWakeDetectEn,
    output logic canWakeFlagClr,
    output logic resetLevelSelect,
    output logic wakeSampleA,
    output logic wakeSampleB,
    output logic wakeA,
    output logic wakeB,
    output logic resetOnTick,
    output logic [12:0] statusOut
);

    // ************************************************************
    // control register (low 13 bits, address field read back)
    // ************************************************************
    logic [12:0] ctrl_reg;
    logic [12:0] ctrl_next;
    logic ctrlWr;
    logic statWr;

    assign ctrlWr = wrReq.valid && wrReq.addr == SBCIC_ADDR_CTRL;
    assign statWr = wrReq.valid && wrReq.addr == SBCIC_ADDR_STAT;

    // control register has its own lock bit; honoured the same way
    always_comb
    begin
        ctrl_next = ctrl_reg;
        if (ctrlWr && !ctrl_reg[SBCIC_BIT_LOCK])
            ctrl_next = wrReq.data & SBCIC_CTRL_MASK;
        else if (ctrlWr)
            ctrl_next[SBCIC_BIT_LOCK] = wrReq.data[SBCIC_BIT_LOCK];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            ctrl_reg <= SBCIC_CTRL_RESET;
        else
            ctrl_reg <= ctrl_next;
    end

    // ************************************************************
    // transceiver and threshold steering
    // ************************************************************
    logic canStandby;
    logic normalMode;
    assign canStandby = ctrl_reg[SBCIC_BIT_CANSTBY];
    assign normalMode = chipModeField[1];

    // transceiver mode from standby bit and chip mode
    always_comb
    begin
        if (canStandby)
            canXcvrMode = SBCIC_XCVR_LOWPWR;
        else if (normalMode)
            canXcvrMode = SBCIC_XCVR_ACTIVE;
        else
            canXcvrMode = SBCIC_XCVR_OFF;
    end

    assign canWakeDetectEn = canStandby;
    assign canWakeFlagClr = !canStandby && normalMode;
    assign resetLevelSelect = ctrl_reg[SBCIC_BIT_RSTLVL];
    assign wakeSampleA = ctrl_reg[SBCIC_BIT_WSAMPA];
    assign wakeSampleB = ctrl_reg[SBCIC_BIT_WSAMPB];

    // ************************************************************
    // wake input sampling
    // ************************************************************
    logic wakeA_reg;
    logic wakeB_reg;
    logic wakeA_next;
    logic wakeB_next;

    // sampled mode only updates while bias is high, so a glitch between strobes is missed
    always_comb
    begin
        wakeA_next = wakeA_reg;
        wakeB_next = wakeB_reg;
        if (!wakeSampleA || wakeBiasOutput)
            wakeA_next = wakeInputA;
        if (!wakeSampleB || wakeBiasOutput)
            wakeB_next = wakeInputB;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            wakeA_reg <= 1'b0;
            wakeB_reg <= 1'b0;
        end
        else
        begin
            wakeA_reg <= wakeA_next;
            wakeB_reg <= wakeB_next;
        end
    end

    assign wakeA = wakeA_reg;
    assign wakeB = wakeB_reg;

    // ************************************************************
    // status register: lock bit and pending flags
    // ************************************************************
    logic lock_reg;
    logic lock_next;
    logic [12:0] clrMask;
    logic [12:0] setMask;
    logic [12:0] flags;

    // lock bit itself stays writable so software can release it
    always_comb
    begin
        lock_next = lock_reg;
        if (statWr)
            lock_next = wrReq.data[SBCIC_BIT_LOCK];
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            lock_reg <= SBCIC_STAT_RESET[SBCIC_BIT_LOCK];
        else
            lock_reg <= lock_next;
    end

    // write-one-to-clear, blocked while locked; reserved bits masked
    assign clrMask = (statWr && !lock_reg) ? (wrReq.data & SBCIC_STAT_FLAGS)
        : 13'h0000;

    // event sources for each flag
    always_comb
    begin
        setMask = 13'h0000;
        setMask[SBCIC_BIT_MAINUV] = evt.mainUv && ctrl_reg[SBCIC_BIT_MAINUVEN];
        setMask[SBCIC_BIT_XCVRUV] = evt.xcvrUv && ctrl_reg[SBCIC_BIT_XCVRUVEN];
        setMask[SBCIC_BIT_LINA] = evt.linA;
        setMask[SBCIC_BIT_LINB] = evt.linB;
        setMask[SBCIC_BIT_TICK] = evt.wdOverflow && wdTimeoutMode;
        setMask[SBCIC_BIT_WAKEA] = evt.wakeA;
        setMask[SBCIC_BIT_PWRUP] = leaveOff;
        setMask[SBCIC_BIT_WAKEB] = evt.wakeB;
        setMask[SBCIC_BIT_CANWK] = evt.canWake && canStandby;
    end

    // one sticky cell per flag bit
    genvar gi;
    generate
        for (gi = 0; gi < 13; gi++)
        begin : g_flag
            if (SBCIC_STAT_FLAGS[gi])
            begin : g_live
                sbcic_flag #(
                    .RESET_VAL(SBCIC_STAT_RESET[gi])
                ) u_flag (
                    .clk(clk),
                    .rstn(rstn),
                    .setEvt(setMask[gi]),
                    .clrReq(clrMask[gi]),
                    .flag(flags[gi])
                );
            end
            else if (gi == SBCIC_BIT_LOCK)
            begin : g_lock
                assign flags[gi] = lock_reg;
            end
            else
            begin : g_rsvd
                assign flags[gi] = 1'b0;
            end
        end
    endgenerate

    assign statusOut = flags;

    // overflow with cyclic already pending asks the chip for a system reset
    assign resetOnTick = evt.wdOverflow && wdTimeoutMode && flags[SBCIC_BIT_TICK];

    // ************************************************************
    // read data register
    // ************************************************************
    logic [15:0] rdData_reg;
    logic [15:0] rdData_next;

    always_comb
    begin
        case (rdAddr)
            SBCIC_ADDR_CTRL: rdData_next = {SBCIC_ADDR_CTRL, ctrl_reg};
            SBCIC_ADDR_STAT: rdData_next = {SBCIC_ADDR_STAT, flags};
            default: rdData_next = {rdAddr, 13'h0000};
        endcase
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            rdData_reg <= 16'h0000;
        else
            rdData_reg <= rdData_next;
    end

    assign rdData = rdData_reg;

    // ************************************************************
    // checks
    // ************************************************************
    sequence s_w1c;
        statWr && !lock_reg && wrReq.data[SBCIC_BIT_TICK] && !setMask[SBCIC_BIT_TICK];
    endsequence

    property p_clear;
        @(posedge clk) disable iff (!rstn) s_w1c |=> !flags[SBCIC_BIT_TICK];
    endproperty
    a_clear: assert property (p_clear) else $error("flag not cleared by one");

    property p_locked;
        @(posedge clk) disable iff (!rstn)
            (statWr && lock_reg && setMask == 13'h0000) |=> $stable(flags[11:0]);
    endproperty
    a_locked: assert property (p_locked) else $error("locked status changed");

    property p_rsvd;
        @(posedge clk) disable iff (!rstn)
            (rdAddr == SBCIC_ADDR_STAT) |=> rdData[2:0] == 3'h0 && flags[2:0] == 3'h0;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits nonzero");

    property p_pwrup;
        @(posedge clk) disable iff (!rstn) leaveOff |=> flags[SBCIC_BIT_PWRUP];
    endproperty
    a_pwrup: assert property (p_pwrup) else $error("power-on flag not set");

    property p_uven;
        @(posedge clk) disable iff (!rstn)
            (!ctrl_reg[SBCIC_BIT_MAINUVEN] && !flags[SBCIC_BIT_MAINUV])
                |=> !$rose(flags[SBCIC_BIT_MAINUV]);
    endproperty
    a_uven: assert property (p_uven) else $error("undervoltage flag while disabled");

    property p_canoff;
        @(posedge clk) disable iff (!rstn)
            (!canStandby && !normalMode)
                |-> canXcvrMode == SBCIC_XCVR_OFF && !setMask[SBCIC_BIT_CANWK];
    endproperty
    a_canoff: assert property (p_canoff) else $error("transceiver not off");

    property p_canact;
        @(posedge clk) disable iff (!rstn)
            (!canStandby && normalMode) |-> canXcvrMode == SBCIC_XCVR_ACTIVE && canWakeFlagClr;
    endproperty
    a_canact: assert property (p_canact) else $error("transceiver not active");

    property p_tick;
        @(posedge clk) disable iff (!rstn)
            (evt.wdOverflow && wdTimeoutMode) |=> flags[SBCIC_BIT_TICK];
    endproperty
    a_tick: assert property (p_tick) else $error("cyclic flag not set");

endmodule : sbcic_ctrl_status

// ---- sbcic_pkg.sv ----
// package: register layout, reset values and types for the interrupt control/status block
package sbcic_pkg;

    // ************************************************************
    // register addresses (3-bit address field of each frame)
    // ************************************************************
    localparam logic [2:0] SBCIC_ADDR_CTRL = 3'h2;
    localparam logic [2:0] SBCIC_ADDR_STAT = 3'h3;

    // ************************************************************
    // field positions
    // ************************************************************
    localparam int SBCIC_BIT_LOCK = 12;
    localparam int SBCIC_BIT_MAINUV = 11;
    localparam int SBCIC_BIT_XCVRUV = 10;
    localparam int SBCIC_BIT_LINA = 9;
    localparam int SBCIC_BIT_LINB = 8;
    localparam int SBCIC_BIT_TICK = 7;
    localparam int SBCIC_BIT_WAKEA = 6;
    localparam int SBCIC_BIT_PWRUP = 5;
    localparam int SBCIC_BIT_WAKEB = 4;
    localparam int SBCIC_BIT_CANWK = 3;
    localparam int SBCIC_BIT_CANSTBY = 3;
    localparam int SBCIC_BIT_RSTLVL = 2;
    localparam int SBCIC_BIT_WSAMPA = 1;
    localparam int SBCIC_BIT_WSAMPB = 0;
    localparam int SBCIC_BIT_MAINUVEN = 11;
    localparam int SBCIC_BIT_XCVRUVEN = 10;

    // flag bits 11..3 are clearable; reserved 2..0 always zero
    localparam logic [12:0] SBCIC_STAT_FLAGS = 13'h0FF8;
    localparam logic [12:0] SBCIC_CTRL_MASK = 13'h1FFF;

    // ************************************************************
    // reset values
    // ************************************************************
    localparam logic [12:0] SBCIC_STAT_RESET = 13'h0020;
    localparam logic [12:0] SBCIC_CTRL_RESET = 13'h0000;

    // ************************************************************
    // types
    // ************************************************************
    typedef enum logic [1:0] {SBCIC_XCVR_ACTIVE, SBCIC_XCVR_OFF, SBCIC_XCVR_LOWPWR} sbcic_xcvr_t;

    // write request from the serial frame decoder
    typedef struct packed {
        logic valid;
        logic [2:0] addr;
        logic [12:0] data;
    } sbcic_wr_t;

    // hardware events raised by the rest of the chip
    typedef struct packed {
        logic mainUv;
        logic xcvrUv;
        logic linA;
        logic linB;
        logic wdOverflow;
        logic wakeA;
        logic wakeB;
        logic canWake;
    } sbcic_evt_t;

endpackage : sbcic_pkg

// ---- sbcic_flag.sv ----
// module: one sticky pending flag with write-one-to-clear
`timescale 1ns/1ns
module sbcic_flag
    import sbcic_pkg::*;
#(
    parameter logic RESET_VAL = 1'b0
)(
    input wire logic clk,
    input wire logic rstn,
    input wire logic setEvt,
    input wire logic clrReq,
    output logic flag
);

    logic flag_reg;
    logic flag_next;

    // set wins over a clear in the same cycle, so no event is lost
    always_comb
    begin
        flag_next = flag_reg;
        if (clrReq)
            flag_next = 1'b0;
        if (setEvt)
            flag_next = 1'b1;
    end

    always_ff @(posedge clk or negedge rstn)
    begin
        if (!rstn)
            flag_reg <= RESET_VAL;
        else
            flag_reg <= flag_next;
    end

    assign flag = flag_reg;

endmodule : sbcic_flag

// ---- sbcic_host_model.sv ----
// file: host-side model that posts register writes and read addresses
`timescale 1ns/1ns
module sbcic_host_model
    import sbcic_pkg::*;
(
    input wire logic clk,
    output sbcic_wr_t wrReq,
    output logic [2:0] rdAddr
);
    // idle bus at time zero, no write pending
    initial
    begin
        wrReq = '0;
        rdAddr = 3'h0;
    end

    // caller sits at a falling edge; the word then stands across one rising edge
    task automatic post(input logic v, input logic [2:0] a, input logic [12:0] d);
        wrReq = '{v, a, d}; // flags are only cleared by ones in d
    endtask : post

    // read address is a level, answer arrives one cycle later
    task automatic read(input logic [2:0] a);
        rdAddr = a;
    endtask : read
endmodule : sbcic_host_model

// ---- sbc_interrupt_ctrl_status_tb.sv ----
// file: self-checking bench for the interrupt control and status block
`timescale 1ns/1ns
module sbc_interrupt_ctrl_status_tb
    import sbcic_pkg::*;
;
    logic clk, rstn, leaveOff, wdTimeoutMode, wakeBiasOutput, wakeInputA, wakeInputB;
    logic canWakeDetectEn, canWakeFlagClr, resetLevelSelect, wakeSampleA, wakeSampleB;
    logic wakeA, wakeB, resetOnTick, tm, lo;
    logic [1:0] chipModeField, md;
    logic [2:0] rdAddr;
    logic [15:0] rdData;
    logic [12:0] statusOut, mStat, mCtrl;
    sbcic_wr_t wrReq;
    sbcic_evt_t evt;
    sbcic_xcvr_t canXcvrMode;
    int error_cnt, comparisons;
    logic [31:0] r;
    logic [2:0] ra;
    sbcic_evt_t ev;

    sbcic_host_model host (.clk(clk), .wrReq(wrReq), .rdAddr(rdAddr));

    sbcic_ctrl_status dut (.clk(clk), .rstn(rstn), .wrReq(wrReq), .rdAddr(rdAddr),
        .rdData(rdData), .evt(evt), .chipModeField(chipModeField), .leaveOff(leaveOff),
        .wdTimeoutMode(wdTimeoutMode), .wakeBiasOutput(wakeBiasOutput),
        .wakeInputA(wakeInputA), .wakeInputB(wakeInputB), .canXcvrMode(canXcvrMode),
        .canWakeDetectEn(canWakeDetectEn), .canWakeFlagClr(canWakeFlagClr),
        .resetLevelSelect(resetLevelSelect), .wakeSampleA(wakeSampleA),
        .wakeSampleB(wakeSampleB), .wakeA(wakeA), .wakeB(wakeB),
        .resetOnTick(resetOnTick), .statusOut(statusOut));

    // ****************************************
    // compare and closing tasks
    // ****************************************
    task automatic chkReg(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chkReg

    task automatic chkBit(input logic got, input logic exp);
        chkReg({15'h0, got}, {15'h0, exp});
    endtask : chkBit

    task automatic summarize();
        $display("errors %0d comparisons %0d", error_cnt, comparisons);
        if (error_cnt == 0 && comparisons > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : summarize

    // ****************************************
    // one cycle: check last edge, apply inputs, update the model
    // ****************************************
    task automatic step(input logic w, input logic [2:0] a, input logic [12:0] d,
        input sbcic_evt_t e);
        logic [12:0] setM;
        logic [12:0] clr;
        sbcic_xcvr_t xm;
        logic [15:0] gotS;
        logic [15:0] expS;
        logic [15:0] gotC;
        logic [15:0] expC;
        @(negedge clk);
        xm = mCtrl[3] ? SBCIC_XCVR_LOWPWR :
            (chipModeField[1] ? SBCIC_XCVR_ACTIVE : SBCIC_XCVR_OFF);
        gotS = {3'h0, statusOut};
        expS = {3'h0, mStat};
        gotC = {9'h0, canXcvrMode, canWakeDetectEn, canWakeFlagClr, resetLevelSelect,
            wakeSampleA, wakeSampleB};
        expC = {9'h0, xm, mCtrl[3], ~mCtrl[3] & chipModeField[1], mCtrl[2:0]};
        chkReg(gotS, expS);
        chkReg(gotC, expC);
        host.post(w, a, d);
        evt = e;
        chipModeField = md;
        wdTimeoutMode = tm;
        leaveOff = lo;
        lo = 1'b0;
        #1;
        chkBit(resetOnTick, e.wdOverflow & tm & mStat[7]);
        @(posedge clk);
        // gating uses the control value held before this edge
        setM = {1'b0, e.mainUv & mCtrl[11], e.xcvrUv & mCtrl[10], e.linA, e.linB,
            e.wdOverflow & tm, e.wakeA, leaveOff, e.wakeB, e.canWake & mCtrl[3], 3'h0};
        clr = 13'h0;
        if (w && a == SBCIC_ADDR_STAT)
        begin
            clr = mStat[12] ? 13'h0 : (d & SBCIC_STAT_FLAGS);
            mStat[12] = d[12];
        end
        if (w && a == SBCIC_ADDR_CTRL)
            mCtrl = mCtrl[12] ? {d[12], mCtrl[11:0]} : d;
        mStat = (mStat & ~clr) | setM; // set beats clear
    endtask : step

    // quiet bus, then read back one register
    task automatic rd(input logic [2:0] a, input logic [12:0] v);
        @(negedge clk);
        host.post(1'b0, 3'h0, 13'h0);
        host.read(a);
        evt = '0;
        leaveOff = 1'b0;
        repeat (2) @(negedge clk);
        chkReg(rdData, {a, v});
    endtask : rd

    task automatic doReset();
        rstn = 1'b0;
        mStat = SBCIC_STAT_RESET;
        mCtrl = SBCIC_CTRL_RESET;
        repeat (2) @(posedge clk);
        @(negedge clk);
        rstn = 1'b1;
    endtask : doReset

    // ****************************************
    // clock, watchdog, main sequence
    // ****************************************
    initial
    begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end

    // run needs about 700 cycles; far beyond that means a hang
    initial
    begin
        #100000;
        error_cnt++;
        summarize();
    end

    initial
    begin
        evt = '0;
        chipModeField = 2'h0;
        leaveOff = 1'b0;
        wdTimeoutMode = 1'b0;
        wakeBiasOutput = 1'b0;
        wakeInputA = 1'b0;
        wakeInputB = 1'b0;
        md = 2'h0;
        tm = 1'b0;
        lo = 1'b0;
        error_cnt = 0;
        comparisons = 0;
        void'($urandom(32'h0CDA));
        doReset();
        rd(SBCIC_ADDR_STAT, 13'h0020);
        rd(3'h5, 13'h0000);
        step(1'b1, SBCIC_ADDR_CTRL, 13'h0006, '0);
        rd(SBCIC_ADDR_CTRL, 13'h0006);
        wakeInputA = 1'b1;
        wakeInputB = 1'b1;
        rd(SBCIC_ADDR_CTRL, 13'h0006);
        chkBit(wakeA, 1'b0);
        chkBit(wakeB, 1'b1);
        wakeBiasOutput = 1'b1;
        rd(SBCIC_ADDR_CTRL, 13'h0006);
        chkBit(wakeA, 1'b1);
        // second input held between strobes, first one follows its pin
        step(1'b1, SBCIC_ADDR_CTRL, 13'h0001, '0);
        rd(SBCIC_ADDR_CTRL, 13'h0001);
        wakeBiasOutput = 1'b0;
        wakeInputA = 1'b0;
        wakeInputB = 1'b0;
        rd(SBCIC_ADDR_CTRL, 13'h0001);
        chkBit(wakeA, 1'b0);
        chkBit(wakeB, 1'b1);
        wakeBiasOutput = 1'b1;
        rd(SBCIC_ADDR_CTRL, 13'h0001);
        chkBit(wakeB, 1'b0);
        // every mode with standby on, then off
        step(1'b1, SBCIC_ADDR_CTRL, 13'h0C08, '0);
        for (int m = 0; m < 8; m++)
        begin
            md = m[1:0];
            if (m == 4)
                step(1'b1, SBCIC_ADDR_CTRL, 13'h0000, '0);
            step(1'b0, 3'h0, 13'h0, '1);
            step(1'b1, SBCIC_ADDR_STAT, 13'h0FF8, '0);
        end
        tm = 1'b1;
        step(1'b0, 3'h0, 13'h0, '{wdOverflow: 1'b1, default: 1'b0});
        tm = 1'b1;
        step(1'b0, 3'h0, 13'h0, '{wdOverflow: 1'b1, default: 1'b0});
        lo = 1'b1;
        step(1'b1, SBCIC_ADDR_STAT, 13'h1FFF, '0);
        step(1'b0, 3'h0, 13'h0, '1);
        step(1'b1, SBCIC_ADDR_STAT, 13'h1FF8, '0);
        step(1'b1, SBCIC_ADDR_STAT, 13'h0000, '0);
        rd(SBCIC_ADDR_STAT, mStat);
        step(1'b1, SBCIC_ADDR_CTRL, 13'h1000, '0);
        step(1'b1, SBCIC_ADDR_CTRL, 13'h0008, '0);
        step(1'b1, SBCIC_ADDR_CTRL, 13'h0000, '0);
        // random traffic, sparse events
        repeat (600)
        begin
            r = $urandom;
            md = r[1:0];
            tm = r[2];
            lo = (r[7:3] == 5'h0);
            ra = r[8] ? SBCIC_ADDR_STAT : SBCIC_ADDR_CTRL;
            ev = sbcic_evt_t'(8'($urandom & $urandom & $urandom));
            step(r[10:9] == 2'h0, ra, 13'($urandom), ev);
        end
        step(1'b0, 3'h0, 13'h0, '0);
        rd(SBCIC_ADDR_CTRL, mCtrl);
        // reset again at the end of the run
        doReset();
        rd(SBCIC_ADDR_STAT, 13'h0020);
        summarize();
    end
endmodule : sbc_interrupt_ctrl_status_tb
